//--- slsd_driver.sv
// serial-in latched open-drain sink driver, built on the system clock
`timescale 1ns/1ns

// Overview of operation
// - eight-stage shift chain feeds an eight-bit storage stage
// - each shift clock rising edge shifts one stage, taking the serial input
// - each latch clock rising edge copies the chain into storage, clocks independent
// - cascade output changes on shift clock rise, showing the last stage, next out
// - storage reaches the output buffers only while shift clear is high
// - shift clear low forces every shift chain stage to zero
// - output enable high forces all buffer bits low, sinks off
// - output enable low makes buffers follow storage without a clock edge
// - a zero buffer bit switches its sink transistor off
// - a one buffer bit switches its open-drain transistor on to sink
// - chained devices link cascade out to data in, sharing both clocks
module slsd_driver (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // host pins
  input wire slsd_pkg::slsd_pins_t pins,
  // cascade and sink drains
  output logic serial_cascade_out,
  output logic [slsd_pkg::STAGES-1:0] sink_out,
  output logic [slsd_pkg::STAGES-1:0] sink_oe
);
  import slsd_pkg::*;

  // ********************
  // pin synchronisers
  // ********************
  slsd_pins_t meta_q, meta_d;
  slsd_pins_t sync_q, sync_d;
  slsd_pins_t prev_q, prev_d;
  // second and third stages only; first stage is read by nothing else
  always_comb begin
    meta_d = pins;
    sync_d = meta_q;
    prev_d = sync_q;
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // edges are judged at the second stage against a third flop; a level held
  // for under one system clock may slip between samples
  logic shift_rise;
  logic latch_rise;
  assign shift_rise = sync_q.shift_clock & ~prev_q.shift_clock;
  assign latch_rise = sync_q.latch_clock & ~prev_q.latch_clock;

  // ********************
  // gate decode
  // ********************
  // storage reaches the buffers only with enable low and clear high
  function automatic logic gate_open(input slsd_pins_t p);
    return !p.output_enable_n && p.shift_clear_n;
  endfunction

  // ********************
  // shift chain
  // ********************
  logic [STAGES-1:0] chain_q, chain_d;

  // a shift edge seen while clear is low is dropped, not held over
  always_comb begin
    chain_d = chain_q;
    if (!sync_q.shift_clear_n) begin
      chain_d = CHAIN_RESET;
    end else if (shift_rise) begin
      chain_d = {chain_q[STAGES-2:0], sync_q.serial_data_in};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      chain_q <= CHAIN_RESET;
    end else begin
      chain_q <= chain_d;
    end
  end

  // ********************
  // cascade output
  // ********************
  // shows the last stage as it stands after each shift, so the next device in
  // line takes it on the following shift; a clear leaves it alone until then
  logic cascade_q, cascade_d;

  always_comb begin
    cascade_d = cascade_q;
    if (sync_q.shift_clear_n && shift_rise) begin
      cascade_d = chain_q[STAGES-2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cascade_q <= CASCADE_RESET;
    end else begin
      cascade_q <= cascade_d;
    end
  end

  // ********************
  // storage stage
  // ********************
  logic [STAGES-1:0] store_q, store_d;

  // clear empties the chain and turns the buffers off; storage keeps its word
  always_comb begin
    store_d = store_q;
    // latch samples the chain as it stood before any simultaneous shift
    if (latch_rise) begin
      store_d = chain_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      store_q <= LATCH_RESET;
    end else begin
      store_q <= store_d;
    end
  end

  // ********************
  // output buffers
  // ********************
  logic [STAGES-1:0] sink_q, sink_d;

  // buffers take this edge's storage value, so a latch reaches the sinks
  // with no extra cycle; clear low blocks storage, as does enable high
  always_comb begin
    if (gate_open(sync_q)) begin
      sink_d = store_d;
    end else begin
      sink_d = SINK_OFF;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sink_q <= SINK_OFF;
    end else begin
      sink_q <= sink_d;
    end
  end

  // ********************
  // open-drain sinks
  // ********************
  // open drain: only ever pulls low, enable high while sinking
  assign serial_cascade_out = cascade_q;
  for (genvar g = 0; g < STAGES; g++) begin : g_sink
    assign sink_out[g] = SINK_OFF[g];
    assign sink_oe[g] = sink_q[g];
    a_bit_follows: assert property (@(posedge sys_clk) disable iff (reset)
      sink_oe[g] |-> store_q[g])
      else $error("sink on for a zero storage bit");
  end

  // ********************
  // assertions
  // ********************
  // checks read the synchronised pins, one register ahead of the state
  a_clear_empties_chain: assert property (@(posedge sys_clk) disable iff (reset)
    !sync_q.shift_clear_n |=> chain_q == 8'h00)
    else $error("chain not cleared");
  a_shift_takes_bit: assert property (@(posedge sys_clk) disable iff (reset)
    shift_rise && sync_q.shift_clear_n |=> chain_q[0] == $past(sync_q.serial_data_in))
    else $error("shift did not take input bit");
  a_cascade_last_bit: assert property (@(posedge sys_clk) disable iff (reset)
    shift_rise && sync_q.shift_clear_n |=> serial_cascade_out == $past(chain_q[STAGES-2]))
    else $error("cascade bit wrong");
  a_cascade_holds: assert property (@(posedge sys_clk) disable iff (reset)
    !shift_rise |=> $stable(serial_cascade_out))
    else $error("cascade moved without shift edge");
  a_latch_copies: assert property (@(posedge sys_clk) disable iff (reset)
    latch_rise |=> store_q == $past(chain_q))
    else $error("latch missed chain");
  a_store_holds: assert property (@(posedge sys_clk) disable iff (reset)
    !latch_rise |=> $stable(store_q))
    else $error("storage changed without latch edge");
  a_disable_off: assert property (@(posedge sys_clk) disable iff (reset)
    sync_q.output_enable_n |=> sink_oe == 8'h00)
    else $error("sinks on while disabled");
  a_enable_follows: assert property (@(posedge sys_clk) disable iff (reset)
    !sync_q.output_enable_n && sync_q.shift_clear_n |=> sink_oe == store_q)
    else $error("sinks not following storage");
  a_clear_blocks: assert property (@(posedge sys_clk) disable iff (reset)
    !sync_q.shift_clear_n |=> sink_oe == 8'h00)
    else $error("storage passed during clear");
  a_drain_low: assert property (@(posedge sys_clk) disable iff (reset)
    sink_out == 8'h00)
    else $error("drain driven high");
  a_chain_steps: assert property (@(posedge sys_clk) disable iff (reset)
    shift_rise && sync_q.shift_clear_n |=> chain_q[STAGES-1:1] == $past(chain_q[STAGES-2:0]))
    else $error("chain did not advance one stage");
  a_chain_holds: assert property (@(posedge sys_clk) disable iff (reset)
    !shift_rise && sync_q.shift_clear_n |=> $stable(chain_q))
    else $error("chain moved without shift edge");
  a_cascade_feeds: assert property (@(posedge sys_clk) disable iff (reset)
    shift_rise && sync_q.shift_clear_n |=> serial_cascade_out == chain_q[STAGES-1])
    else $error("cascade not showing last stage");
  a_cascade_clear: assert property (@(posedge sys_clk) disable iff (reset)
    !sync_q.shift_clear_n |=> $stable(serial_cascade_out))
    else $error("cascade moved during clear");
  a_store_kept_clear: assert property (@(posedge sys_clk) disable iff (reset)
    !sync_q.shift_clear_n && !latch_rise |=> $stable(store_q))
    else $error("storage disturbed by clear");
  a_sinks_gated: assert property (@(posedge sys_clk) disable iff (reset)
    sink_oe != SINK_OFF |-> $past(!sync_q.output_enable_n && sync_q.shift_clear_n))
    else $error("sinks on with gate closed");
  a_latch_transparent: assert property (@(posedge sys_clk) disable iff (reset)
    latch_rise && gate_open(sync_q) |=> sink_oe == $past(chain_q))
    else $error("latched data late at sinks");
endmodule // slsd_driver

//--- slsd_pkg.sv
// package of constants and carrier types for the serial latched sink driver
package slsd_pkg;
  localparam int STAGES = 8;
  localparam logic [7:0] CHAIN_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] SINK_OFF = 8'h00;
  localparam logic CASCADE_RESET = 1'b0;
  localparam int SYNC_DEPTH = 2;

  // pins from the host, sampled together
  typedef struct packed {
    logic shift_clock;
    logic latch_clock;
    logic serial_data_in;
    logic shift_clear_n;
    logic output_enable_n;
  } slsd_pins_t;
endpackage

//--- slsd_host.sv
// host model that shifts bytes into the driver chain and latches them
`timescale 1ns/1ns
module slsd_host (
  // clock
  input wire logic sys_clk,
  // pins to the driver
  output slsd_pkg::slsd_pins_t pins
);
  import slsd_pkg::*;
  // clocks low at time zero so reset release sees no false edge
  initial pins = 5'h03;
  task automatic hold();
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      pins.serial_data_in <= b[i];
      hold();
      pins.shift_clock <= 1'b1;
      hold();
      pins.shift_clock <= 1'b0;
      hold();
    end
  endtask
  task automatic latch();
    pins.latch_clock <= 1'b1;
    hold();
    pins.latch_clock <= 1'b0;
    hold();
  endtask
endmodule // slsd_host

//--- slsd_driver_bench.sv
// testbench: two chained drivers fed by the host model
`timescale 1ns/1ns
module slsd_driver_bench;
  import slsd_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  slsd_pins_t pins;
  slsd_pins_t pins_b;
  logic cascade;
  logic [7:0] sink_oe;
  logic [7:0] sink_oe_b;
  logic [7:0] sink_out;
  int failures = 0;
  int n_tests = 0;
  always #10 sys_clk = ~sys_clk;
  // second device takes the cascade as its data, clocks shared
  assign pins_b = {pins[4:3], cascade, pins[1:0]};
  slsd_host host (.sys_clk(sys_clk), .pins(pins));
  slsd_driver uut (.sys_clk(sys_clk), .reset(reset), .pins(pins),
    .serial_cascade_out(cascade), .sink_out(sink_out), .sink_oe(sink_oe));
  slsd_driver uut_b (.sys_clk(sys_clk), .reset(reset), .pins(pins_b),
    .serial_cascade_out(), .sink_out(), .sink_oe(sink_oe_b));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic lv(input logic clr_n, input logic oe_n);
    host.pins.shift_clear_n <= clr_n;
    host.pins.output_enable_n <= oe_n;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic t_load();
    lv(1'b1, 1'b0);
    host.send(8'hA5);
    chk("cascade first", 8'h01, {7'h00, cascade});
    host.send(8'h3C);
    host.latch();
    chk("sink_oe", 8'h3C, sink_oe);
    chk("chained sink_oe", 8'hA5, sink_oe_b);
    chk("cascade last", 8'h00, {7'h00, cascade});
    chk("sink_out", 8'h00, sink_out);
    $display("load test done");
  endtask
  task automatic t_gate();
    lv(1'b1, 1'b1);
    chk("sink_oe off", 8'h00, sink_oe);
    lv(1'b1, 1'b0);
    chk("sink_oe on", 8'h3C, sink_oe);
    lv(1'b0, 1'b0);
    chk("sink_oe clear", 8'h00, sink_oe);
    host.send(8'hFF);
    lv(1'b1, 1'b0);
    chk("sink_oe kept", 8'h3C, sink_oe);
    host.latch();
    chk("sink_oe emptied", 8'h00, sink_oe);
    $display("gate test done");
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_load();
    t_gate();
    give_verdict();
  end
  // about 255 cycles expected; over four times that is a hang
  initial begin
    #24000;
    failures++;
    give_verdict();
  end
endmodule // slsd_driver_bench
